// ===== src/wwcs_map.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by bare name; definitions only
`ifndef WWCS_MAP_SVH
`define WWCS_MAP_SVH
`define WWCS_OFF_CTRL      12'h000
`define WWCS_OFF_CFG       12'h004
`define WWCS_OFF_STAT      12'h008
`define WWCS_CTRL_ACT_BIT  7
`define WWCS_CFG_EWI_BIT   9
`define WWCS_CFG_TB_LSB    7
`define WWCS_STAT_FLAG_BIT 0
`define WWCS_CNT_RESET     7'h7F
`define WWCS_WIN_RESET     7'h7F
`define WWCS_TB_RESET      2'h0
`define WWCS_EARLY_VALUE   7'h40
`define WWCS_PRE_EARLY     7'h41
`define WWCS_BASE_DIV      4096
`define WWCS_RST_PULSE     2'h2
`endif

// ===== src/wwcs_pkg.sv
// types shared by the window watchdog files
// assumes: nothing beyond the map header
`default_nettype none
package wwcs_pkg;
  // one apb request as the slave sees it in the access phase
  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } wwcs_apb_req_t;
  // configuration fields
  typedef struct packed {
    logic       early_wake_irq_enable;
    logic [1:0] tb;
    logic [6:0] window;
  } wwcs_cfg_t;
endpackage
`default_nettype wire

// ===== src/wwcs_prescaler.sv
// counter time base: clk_sys / base_div / 2^tb, one-cycle tick
// assumes: base_div of at least 2, tb from a register on clk_sys
`timescale 1ns/1ps
`default_nettype none
module wwcs_prescaler #(
  parameter int BASE_DIV = 4096
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [1:0] tb,
  output logic            tick
);
  localparam int BW = $clog2(BASE_DIV);
  logic [BW-1:0] base_reg;
  logic [BW-1:0] base_next;
  logic [2:0]    stage_reg;
  logic [2:0]    stage_next;
  logic          tick_reg;
  logic          tick_next;

  function automatic logic [2:0] stage_last(input logic [1:0] sel);
    stage_last = 3'((4'h1 << sel) - 4'h1);
  endfunction

  always_comb begin
    base_next  = base_reg + 1'b1;
    stage_next = stage_reg;
    tick_next  = 1'b0;
    if (base_reg == BW'(BASE_DIV - 1)) begin
      base_next = '0;
      // >= so a smaller tb taking effect mid-count cannot run past
      if (stage_reg >= stage_last(tb)) begin
        stage_next = 3'h0;
        tick_next  = 1'b1;
      end else begin
        stage_next = stage_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      base_reg  <= '0;
      stage_reg <= 3'h0;
      tick_reg  <= 1'b0;
    end else begin
      base_reg  <= base_next;
      stage_reg <= stage_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule
`default_nettype wire

// ===== src/wwcs_apb_port.sv
// apb handshake: one wait state, registered pready, prdata, pslverr
// assumes: rdata and hit decoded combinationally from the held request
`timescale 1ns/1ps
`default_nettype none
module wwcs_apb_port (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] rdata,
  input  wire logic        hit,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             commit
);
  logic        pready_reg;
  logic        pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  always_comb begin
    pready_next  = psel && penable && !pready_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    // capture the answer in the first access cycle
    if (pready_next) begin
      prdata_next  = hit ? rdata : 32'h0;
      pslverr_next = !hit;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;
  assign commit  = psel && penable && pready_reg;
endmodule
`default_nettype wire

// ===== src/wwcs_top.sv
// window watchdog: control, configuration and status over apb
// assumes: apb master on clk_sys; reset_request goes to the system
// reset controller, which in turn drives reset_n
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "wwcs_map.svh"
module wwcs_top #(
  parameter int BASE_DIV = `WWCS_BASE_DIV
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq_early_wake,
  output logic             reset_request
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  wwcs_pkg::wwcs_apb_req_t req;
  wwcs_pkg::wwcs_cfg_t     cfg_reg;
  wwcs_pkg::wwcs_cfg_t     cfg_next;
  logic [6:0]              cnt_reg;
  logic [6:0]              cnt_next;
  logic                    act_reg;
  logic                    act_next;
  logic                    flag_reg;
  logic                    flag_next;
  logic                    irq_reg;
  logic                    irq_next;
  logic [1:0]              rst_left_reg;
  logic [1:0]              rst_left_next;
  logic                    rst_req_reg;
  logic                    rst_req_next;
  logic                    tick;
  logic                    commit;
  logic                    wr;
  logic                    ctrl_wr;
  logic                    cfg_wr;
  logic                    stat_wr;
  logic                    reach_early;
  logic                    expire;
  logic                    bad_reload;
  logic                    fire;
  logic [31:0]             rdata;
  logic                    hit;

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `WWCS_OFF_CTRL) || (a == `WWCS_OFF_CFG) ||
               (a == `WWCS_OFF_STAT);
  endfunction

  function automatic logic [31:0] read_mux(
    input logic [11:0]         a,
    input logic                act,
    input logic [6:0]          cnt,
    input wwcs_pkg::wwcs_cfg_t cfg,
    input logic                flag
  );
    read_mux = 32'h0;
    if (a == `WWCS_OFF_CTRL) begin
      read_mux[`WWCS_CTRL_ACT_BIT] = act;
      read_mux[6:0]                = cnt;
    end else if (a == `WWCS_OFF_CFG) begin
      read_mux[`WWCS_CFG_EWI_BIT]                       = cfg.early_wake_irq_enable;
      read_mux[`WWCS_CFG_TB_LSB+1:`WWCS_CFG_TB_LSB]     = cfg.tb;
      read_mux[6:0]                                     = cfg.window;
    end else if (a == `WWCS_OFF_STAT) begin
      read_mux[`WWCS_STAT_FLAG_BIT] = flag;
    end
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************
  // one driver for the whole carrier keeps it a single assignment
  assign req       = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign hit       = addr_hit(req.addr);
  assign rdata     = read_mux(req.addr, act_reg, cnt_reg, cfg_reg,
                              flag_reg);

  wwcs_apb_port u_apb (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .psel    (psel),
    .penable (penable),
    .rdata   (rdata),
    .hit     (hit),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .commit  (commit)
  );

  // writes take effect only at the edge that completes the transfer
  assign wr      = commit && req.write;
  assign ctrl_wr = wr && (req.addr == `WWCS_OFF_CTRL);
  assign cfg_wr  = wr && (req.addr == `WWCS_OFF_CFG);
  assign stat_wr = wr && (req.addr == `WWCS_OFF_STAT);

  // ****************************************************************
  // time base
  // ****************************************************************
  // prescaled counter tick
  wwcs_prescaler #(
    .BASE_DIV (BASE_DIV)
  ) u_pre (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tb      (cfg_reg.tb),
    .tick    (tick)
  );

  // ****************************************************************
  // events
  // ****************************************************************
  // count about to reach 0x40
  assign reach_early = tick && (cnt_reg == `WWCS_PRE_EARLY);
  assign expire      = act_reg && tick && !ctrl_wr &&
                       (cnt_reg == `WWCS_EARLY_VALUE);
  // reload outside window while active, or a reload that clears the top bit while active or activating
  assign bad_reload  = ctrl_wr &&
                       ((act_reg && (cnt_reg > cfg_reg.window)) ||
                        ((act_reg || req.wdata[`WWCS_CTRL_ACT_BIT]) &&
                         !req.wdata[6]));
  assign fire        = expire || bad_reload;

  // ****************************************************************
  // control: activation and downcounter
  // ****************************************************************
  always_comb begin
    act_next = act_reg;
    cnt_next = cnt_reg;
    if (tick) begin
      cnt_next = cnt_reg - 7'h01;
    end
    // a reload in the same cycle as a tick wins
    if (ctrl_wr) begin
      cnt_next = req.wdata[6:0];
      if (req.wdata[`WWCS_CTRL_ACT_BIT]) begin
        act_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      act_reg <= 1'b0;
      cnt_reg <= `WWCS_CNT_RESET;
    end else begin
      act_reg <= act_next;
      cnt_reg <= cnt_next;
    end
  end

  // ****************************************************************
  // configuration
  // ****************************************************************
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_wr) begin
      // enable can be set, never cleared
      cfg_next.early_wake_irq_enable    = cfg_reg.early_wake_irq_enable | req.wdata[`WWCS_CFG_EWI_BIT];
      cfg_next.tb     = req.wdata[`WWCS_CFG_TB_LSB+1:`WWCS_CFG_TB_LSB];
      cfg_next.window = req.wdata[6:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg.early_wake_irq_enable    <= 1'b0;
      cfg_reg.tb     <= `WWCS_TB_RESET;
      cfg_reg.window <= `WWCS_WIN_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ****************************************************************
  // status flag and interrupt
  // ****************************************************************
  always_comb begin
    flag_next = flag_reg;
    // writing zero clears, writing one keeps
    if (stat_wr && !req.wdata[`WWCS_STAT_FLAG_BIT]) begin
      flag_next = 1'b0;
    end
    // set ignores the enable and beats a clear
    if (reach_early) begin
      flag_next = 1'b1;
    end
    // interrupt level gated by the enable
    irq_next = flag_next && cfg_next.early_wake_irq_enable;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      irq_reg  <= irq_next;
    end
  end

  assign irq_early_wake = irq_reg;

  // ****************************************************************
  // reset request
  // ****************************************************************
  // the system is expected to reset us; a held pulse keeps the
  // request visible even if the controller samples slowly
  always_comb begin
    rst_left_next = rst_left_reg;
    if (fire) begin
      rst_left_next = `WWCS_RST_PULSE;
    end else if (rst_left_reg != 2'h0) begin
      rst_left_next = rst_left_reg - 2'h1;
    end
    rst_req_next = (rst_left_next != 2'h0);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_left_reg <= 2'h0;
      rst_req_reg  <= 1'b0;
    end else begin
      rst_left_reg <= rst_left_next;
      rst_req_reg  <= rst_req_next;
    end
  end

  assign reset_request = rst_req_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // tick spacing helper: cycles since the last tick at a steady tb
  logic [15:0] gap_cnt;
  logic        gap_ok;
  logic [1:0]  gap_tb;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt <= 16'h0;
      gap_ok  <= 1'b0;
      gap_tb  <= 2'h0;
    end else begin
      gap_cnt <= tick ? 16'h0 : gap_cnt + 16'h1;
      gap_tb  <= cfg_reg.tb;
      if (tick) begin
        gap_ok <= 1'b1;
      end else if (gap_tb != cfg_reg.tb) begin
        gap_ok <= 1'b0;
      end
    end
  end

  chk_irq_level: assert property (
    irq_early_wake == (flag_reg && cfg_reg.early_wake_irq_enable))
    else $error("interrupt does not follow flag and enable");

  chk_irq_at_early: assert property (
    (tick && cnt_reg == `WWCS_PRE_EARLY && cfg_reg.early_wake_irq_enable) |=> irq_early_wake)
    else $error("no interrupt when count reached 0x40");

  chk_ewi_sticky: assert property (
    cfg_reg.early_wake_irq_enable |=> cfg_reg.early_wake_irq_enable)
    else $error("interrupt enable was cleared");

  chk_tick_gap: assert property (
    (tick && gap_ok && gap_tb == cfg_reg.tb) |->
      (32'(gap_cnt) == (BASE_DIV << cfg_reg.tb) - 1))
    else $error("tick spacing wrong for time base");

  chk_window_write: assert property (
    cfg_wr |=> cfg_reg.window == $past(req.wdata[6:0]))
    else $error("window value not stored");

  chk_flag_set: assert property (
    reach_early |=> flag_reg && cnt_reg == `WWCS_EARLY_VALUE ||
                    flag_reg && $past(ctrl_wr))
    else $error("flag not set on reaching 0x40");

  chk_flag_clear: assert property (
    (stat_wr && !req.wdata[0] && !reach_early) |=> !flag_reg)
    else $error("flag not cleared by writing zero");

  chk_flag_no_ewi: assert property (
    (reach_early && !cfg_next.early_wake_irq_enable) |=> flag_reg && !irq_early_wake)
    else $error("flag depends on interrupt enable");

  chk_reset_expiry: assert property (
    expire |=> reset_request [*2])
    else $error("no reset when count left 0x40");

  chk_reset_window: assert property (
    (ctrl_wr && act_reg && cnt_reg > cfg_reg.window) |=> reset_request)
    else $error("no reset on reload above window");

  chk_free_run: assert property (
    (tick && !ctrl_wr) |=> cnt_reg == $past(cnt_reg) - 7'h01)
    else $error("counter did not decrement");

  chk_act_sticky: assert property (
    act_reg |=> act_reg)
    else $error("activation bit was cleared");

  chk_rst_width: assert property (
    $rose(reset_request) |=> reset_request ##1
      (!reset_request || $past(fire) || $past(fire, 2)))
    else $error("reset request pulse width wrong");

  chk_apb_answer: assert property (
    (psel && penable && !pready) |=> pready)
    else $error("apb answer not after one wait");
endmodule
`default_nettype wire

// ===== tb/window_watchdog_config_status_tb_top.sv
// self-checking bench for the window watchdog register block
// assumes: wwcs_top alone, bench is apb master and reset controller
`timescale 1ns/1ps
`default_nettype none
`include "wwcs_map.svh"
`define CHECK(what, exp, got) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("Error %s expected %h seen %h", what, exp, got); \
  end \
end
module window_watchdog_config_status_tb_top;
  // short base divider keeps expiry runs to a few hundred cycles
  localparam int DIV = 4;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq_early_wake;
  logic        reset_request;
  logic [31:0] rd_v;
  logic        err_v;
  int          fail_count = 0;
  int          n_tests = 0;

  wwcs_top #(.BASE_DIV(DIV)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq_early_wake(irq_early_wake),
    .reset_request(reset_request));

  always #20 clk_sys = ~clk_sys;

  // ****************************************
  // bus and wait helpers
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) `CHECK("pready", 1'b1, pready)
  endtask

  task automatic wait_rr(input int limit, output int waited);
    waited = 0;
    while (reset_request !== 1'b1 && waited < limit) begin
      @(posedge clk_sys);
      waited++;
    end
  endtask

  // width of the reset pulse, then the bench acts as reset controller
  task automatic pulse_and_reset(output int width);
    width = 0;
    while (reset_request === 1'b1 && width < 8) begin
      width++;
      @(posedge clk_sys);
    end
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values;
    apb(1'b0, `WWCS_OFF_CTRL, 32'h0);
    `CHECK("ctrl reset", 32'h0000007F, rd_v)
    `CHECK("ctrl read err", 1'b0, err_v)
    apb(1'b0, `WWCS_OFF_CFG, 32'h0);
    `CHECK("cfg reset", 32'h0000007F, rd_v)
    apb(1'b0, `WWCS_OFF_STAT, 32'h0);
    `CHECK("status reset", 32'h00000000, rd_v)
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    `CHECK("unmapped write err", 1'b1, err_v)
    apb(1'b0, 12'h00C, 32'h0);
    `CHECK("unmapped read", 32'h00000000, rd_v)
    `CHECK("unmapped read err", 1'b1, err_v)
  endtask

  task automatic t_flag_no_irq;
    int n;
    n = 0;
    rd_v = 32'h0;
    while (rd_v[0] !== 1'b1 && n < 150) begin
      apb(1'b0, `WWCS_OFF_STAT, 32'h0);
      n++;
    end
    `CHECK("flag set at 0x40", 32'h00000001, rd_v)
    `CHECK("irq while disabled", 1'b0, irq_early_wake)
    apb(1'b1, `WWCS_OFF_STAT, 32'h00000001);
    apb(1'b0, `WWCS_OFF_STAT, 32'h0);
    `CHECK("flag after write one", 32'h00000001, rd_v)
    apb(1'b1, `WWCS_OFF_STAT, 32'h00000000);
    apb(1'b0, `WWCS_OFF_STAT, 32'h0);
    `CHECK("flag after write zero", 32'h00000000, rd_v)
  endtask

  task automatic t_cfg_fields;
    apb(1'b1, `WWCS_OFF_CFG, 32'hFFFFFFFF);
    `CHECK("cfg write err", 1'b0, err_v)
    apb(1'b0, `WWCS_OFF_CFG, 32'h0);
    `CHECK("cfg all ones", 32'h000003FF, rd_v)
    apb(1'b1, `WWCS_OFF_CFG, 32'h00000000);
    apb(1'b0, `WWCS_OFF_CFG, 32'h0);
    `CHECK("enable kept on zero", 32'h00000200, rd_v)
    apb(1'b1, `WWCS_OFF_CFG, 32'h0000017F);
    apb(1'b0, `WWCS_OFF_CFG, 32'h0);
    `CHECK("tb and window", 32'h0000037F, rd_v)
  endtask

  task automatic t_irq;
    int n;
    apb(1'b1, `WWCS_OFF_CFG, 32'h0000027F);
    n = 0;
    while (irq_early_wake !== 1'b1 && n < 1200) begin
      @(posedge clk_sys);
      n++;
    end
    `CHECK("irq raised", 1'b1, irq_early_wake)
    apb(1'b0, `WWCS_OFF_STAT, 32'h0);
    `CHECK("flag with irq", 32'h00000001, rd_v)
    apb(1'b1, `WWCS_OFF_STAT, 32'h00000000);
    @(posedge clk_sys);
    `CHECK("irq after clear", 1'b0, irq_early_wake)
  endtask

  // sixteen tick periods between samples give exactly 16 decrements
  task automatic t_prescale;
    logic [6:0] c1;
    int         per;
    for (int tb = 0; tb < 4; tb++) begin
      per = DIV << tb;
      apb(1'b1, `WWCS_OFF_CFG, {22'h0, 1'b1, 2'(tb), 7'h7F});
      repeat (70) @(posedge clk_sys);
      apb(1'b0, `WWCS_OFF_CTRL, 32'h0);
      c1 = rd_v[6:0];
      repeat (16 * per - 4) @(posedge clk_sys);
      apb(1'b0, `WWCS_OFF_CTRL, 32'h0);
      `CHECK("ticks per span", 7'h10, 7'(c1 - rd_v[6:0]))
    end
    apb(1'b1, `WWCS_OFF_CFG, 32'h0000007F);
  endtask

  task automatic t_expiry;
    int w;
    apb(1'b1, `WWCS_OFF_CTRL, 32'h000000FF);
    apb(1'b1, `WWCS_OFF_CTRL, 32'h0000007F);
    apb(1'b0, `WWCS_OFF_CTRL, 32'h0);
    `CHECK("activation kept", 1'b1, rd_v[7])
    `CHECK("no early reset", 1'b0, reset_request)
    wait_rr(400, w);
    // reload to 0x7F, 64 ticks of DIV cycles to the 0x40 to 0x3F step
    `CHECK("expiry time", 1'b1, w >= 236 && w <= 264)
    pulse_and_reset(w);
    `CHECK("pulse width", 2, w)
    apb(1'b0, `WWCS_OFF_CTRL, 32'h0);
    `CHECK("ctrl after reset", 32'h0000007F, rd_v)
    apb(1'b0, `WWCS_OFF_CFG, 32'h0);
    `CHECK("cfg after reset", 32'h0000007F, rd_v)
  endtask

  task automatic t_early_reload;
    int w;
    apb(1'b1, `WWCS_OFF_CTRL, 32'h000000FF);
    apb(1'b1, `WWCS_OFF_CFG, 32'h00000050);
    `CHECK("no reset before reload", 1'b0, reset_request)
    apb(1'b1, `WWCS_OFF_CTRL, 32'h000000FF);
    wait_rr(6, w);
    `CHECK("reload above window", 1'b1, reset_request)
    pulse_and_reset(w);
    `CHECK("pulse width", 2, w)
  endtask

  // activating with the top bit clear must reset at once
  task automatic t_top_bit_reload;
    int w;
    apb(1'b1, `WWCS_OFF_CTRL, 32'h00000080);
    wait_rr(6, w);
    `CHECK("reload top bit clear", 1'b1, reset_request)
    pulse_and_reset(w);
    `CHECK("short pulse width", 2, w)
  endtask

  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset_values();
    t_flag_no_irq();
    t_cfg_fields();
    t_irq();
    t_prescale();
    t_expiry();
    t_early_reload();
    t_top_bit_reload();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
